// File: rtl/pcb_defs.svh
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH
`define PCB_CMD_SPECIAL 4'h1
`define PCB_CMD_MEM_RD 4'h6
`define PCB_CMD_MEM_WR 4'h7
`define PCB_CMD_CFG_RD 4'hA
`define PCB_CMD_CFG_WR 4'hB
`define PCB_BE_ALL 4'h0
`define PCB_WIN_BASE 32'h8000_0000
`define PCB_WIN_MASK 32'hFFFF_F000
`define PCB_ABORT_CYC 3'h5
`define PCB_FIFO_DEPTH 8
`endif

// File: rtl/pcb_pkg.sv
`default_nettype none
package pcb_pkg;
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
		logic par;
		logic frame_n;
		logic irdy_n;
		logic trdy_n;
		logic devsel_n;
		logic stop_n;
		logic perr_n;
		logic idsel;
		logic gnt_n;
		logic clkrun_n;
	} pcb_bus_in_t;
	typedef struct packed {
		logic [31:0] ad;
		logic ad_oe;
		logic [3:0] cbe;
		logic cbe_oe;
		logic par;
		logic par_oe;
		logic frame_n;
		logic frame_oe;
		logic irdy_n;
		logic irdy_oe;
		logic trdy_n;
		logic devsel_n;
		logic stop_n;
		logic tgt_oe;
		logic perr_n;
		logic perr_oe;
		logic serr_oe;
		logic req_n;
		logic pme_oe;
		logic inta_oe;
		logic clkrun_oe;
	} pcb_bus_out_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} pcb_dma_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] be;
	} pcb_wr_t;
	typedef enum logic [1:0] {PCB_T_IDLE, PCB_T_DEC, PCB_T_DATA, PCB_T_TURN} pcb_tgt_st_t;
	typedef enum logic [2:0] {PCB_M_IDLE, PCB_M_REQ, PCB_M_ADDR, PCB_M_DATA, PCB_M_TURN} pcb_mst_st_t;
endpackage : pcb_pkg
`default_nettype wire

// File: rtl/pcb_host_port.sv
// Operation
// RQ1: Driver of AD makes AD, CBE and PAR hold even ones.
// RQ2: PAR driven only while AD driven; otherwise an input.
// RQ3: CBE carries command then byte enables; initiator drives it.
// RQ4: Initiator asserts FRAME to start and holds it through the burst.
// RQ5: Target asserts TRDY when it can complete the data phase.
// RQ6: On writes IRDY asserted only while valid data is driven.
// RQ7: On reads IRDY shows the master accepts data.
// RQ8: REQ asserted whenever the device wants to be master.
// RQ9: No master transaction starts before GNT is seen.
// RQ10: Configuration cycles claimed only while IDSEL is asserted.
// RQ11: A target decoding its address drives DEVSEL.
// RQ12: Target STOP makes the master terminate.
// RQ13: A PME output carries wake requests.
// RQ14: CLKRUN sampled for clock state, driven to request the clock.
// RQ15: Interrupt requests go out on interrupt line A.
// RQ16: Data parity errors, except Special Cycle, reported on PERR.
// RQ17: PERR driven when receiving, an input when driving AD.
// RQ18: Address, Special Cycle data and system errors reported on SERR.
// RQ19: All bus logic runs on the single bus clock.
// RQ20: Mode input high selects Cardbus, low conventional bus.
// RQ21: Bus reset releases all outputs and idles the machines.
`include "pcb_defs.svh"
`default_nettype none

module pcb_fifo #(
	parameter int W = 68,
	parameter int D = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready = cnt_q != (AW+1)'(D);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rp_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wp_q <= AW'(wp_q + 1'b1);
			if (pop)
				rp_q <= AW'(rp_q + 1'b1);
			cnt_q <= (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
		end
	end
	always_ff @(posedge ref_clk) begin
		if (push)
			mem_q[wp_q] <= in_data;
	end
endmodule : pcb_fifo

module pcb_host_port
	import pcb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic host_bus_reset_in_n,
	input wire logic card_mode,
	input wire pcb_bus_in_t bus_i,
	output pcb_bus_out_t bus_o,
	output pcb_wr_t wr_o,
	output logic wr_valid,
	input wire logic wr_ready,
	input wire logic [31:0] rd_data,
	input wire logic dma_valid,
	input wire pcb_dma_t dma_i,
	output logic dma_done,
	output logic dma_err,
	input wire logic irq_req,
	input wire logic pme_req,
	input wire logic sys_err,
	output logic perr_seen,
	output logic clk_running
);
	function automatic logic even_sum(logic [31:0] ad, logic [3:0] cbe);
		return ^{ad, cbe};
	endfunction : even_sum

	function automatic logic claims(logic [3:0] cmd, logic [31:0] a, logic idsel);
		return (((cmd == `PCB_CMD_CFG_RD) || (cmd == `PCB_CMD_CFG_WR)) && idsel) ||
			(((cmd == `PCB_CMD_MEM_RD) || (cmd == `PCB_CMD_MEM_WR)) &&
			((a & `PCB_WIN_MASK) == `PCB_WIN_BASE));
	endfunction : claims

	logic brst;
	pcb_tgt_st_t t_st_q;
	pcb_mst_st_t m_st_q;
	logic frame_prev_q, t_wr_q, devsel_n_q, trdy_n_q, stop_n_q, tgt_oe_q;
	logic [31:0] t_addr_q, ad_q;
	logic ad_oe_q, par_q, par_oe_q, req_n_q, frame_n_q, frame_oe_q, irdy_n_q, irdy_oe_q;
	logic [3:0] cbe_q;
	logic cbe_oe_q, m_retry_q, dma_done_q, dma_err_q;
	logic [2:0] m_cnt_q;
	logic [1:0] m_pwin_q;
	logic sum_q, a_chk_q, d_chk_q, s_chk_q, sp_q, perr_n_q, perr_oe_q, serr_oe_q;
	logic perr_seen_q, inta_oe_q, pme_oe_q, clkrun_oe_q, clk_run_q;
	logic addr_ph, t_claim, t_xfer, m_go, m_end, bad, f_in_ready;
	logic [3:0] cbe_cur;
	pcb_wr_t f_in;

	// Either reset idles everything
	assign brst = rst | ~host_bus_reset_in_n; // RQ21
	assign addr_ph = ~bus_i.frame_n & frame_prev_q &
		((m_st_q == PCB_M_IDLE) || (m_st_q == PCB_M_REQ));
	assign t_claim = claims(bus_i.cbe, bus_i.ad, bus_i.idsel); // RQ10
	assign t_xfer = (t_st_q == PCB_T_DATA) & ~bus_i.irdy_n & ~trdy_n_q;
	assign m_go = (m_st_q == PCB_M_REQ) & ~req_n_q & ~bus_i.gnt_n & bus_i.frame_n &
		bus_i.irdy_n & (t_st_q == PCB_T_IDLE) & ~d_chk_q & ~perr_oe_q; // RQ9
	assign m_end = (m_st_q == PCB_M_DATA) & (~bus_i.trdy_n | ~bus_i.stop_n |
		(bus_i.devsel_n & (m_cnt_q == `PCB_ABORT_CYC)));
	assign cbe_cur = cbe_oe_q ? cbe_q : bus_i.cbe;
	assign bad = sum_q ^ bus_i.par;
	assign f_in = '{addr: t_addr_q, data: bus_i.ad, be: bus_i.cbe};

	pcb_fifo #(.W($bits(pcb_wr_t)), .D(`PCB_FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst(brst),
		.in_valid(t_xfer & t_wr_q),
		.in_ready(f_in_ready),
		.in_data(f_in),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(wr_o)
	);

	// Target: fast decode, one data phase, always disconnect
	always_ff @(posedge ref_clk) begin
		if (brst) begin
			t_st_q <= PCB_T_IDLE;
			devsel_n_q <= 1'b1;
			trdy_n_q <= 1'b1;
			stop_n_q <= 1'b1;
			tgt_oe_q <= 1'b0;
			t_wr_q <= 1'b0;
			t_addr_q <= '0;
			frame_prev_q <= 1'b1;
		end else begin
			// Previous frame level finds the address phase
			frame_prev_q <= bus_i.frame_n;
			case (t_st_q)
				PCB_T_IDLE: begin
					if (addr_ph && t_claim) begin
						t_st_q <= PCB_T_DEC;
						tgt_oe_q <= 1'b1;
						devsel_n_q <= 1'b0; // RQ11
						t_wr_q <= bus_i.cbe[0];
						t_addr_q <= bus_i.ad;
					end
				end
				PCB_T_DEC: begin
					t_st_q <= PCB_T_DATA;
					stop_n_q <= 1'b0; // RQ12
					// Full buffer turns the write into a retry
					trdy_n_q <= t_wr_q & ~f_in_ready; // RQ5
				end
				PCB_T_DATA: begin
					if (!bus_i.irdy_n) begin // RQ7
						t_st_q <= PCB_T_TURN;
						devsel_n_q <= 1'b1;
						trdy_n_q <= 1'b1;
						stop_n_q <= 1'b1;
					end
				end
				PCB_T_TURN: begin
					t_st_q <= PCB_T_IDLE;
					tgt_oe_q <= 1'b0;
				end
				default: t_st_q <= PCB_T_IDLE;
			endcase
		end
	end

	// Master: single-word memory write per request
	always_ff @(posedge ref_clk) begin
		if (brst) begin
			m_st_q <= PCB_M_IDLE;
			req_n_q <= 1'b1;
			frame_n_q <= 1'b1;
			frame_oe_q <= 1'b0;
			irdy_n_q <= 1'b1;
			irdy_oe_q <= 1'b0;
			cbe_q <= '0;
			cbe_oe_q <= 1'b0;
			m_cnt_q <= '0;
			m_retry_q <= 1'b0;
			dma_done_q <= 1'b0;
			dma_err_q <= 1'b0;
		end else begin
			dma_done_q <= 1'b0;
			dma_err_q <= 1'b0;
			case (m_st_q)
				PCB_M_IDLE: begin
					if (dma_valid) begin
						m_st_q <= PCB_M_REQ;
						req_n_q <= 1'b0; // RQ8
					end
				end
				PCB_M_REQ: begin
					if (m_go) begin
						m_st_q <= PCB_M_ADDR;
						req_n_q <= 1'b1;
						frame_n_q <= 1'b0; // RQ4
						frame_oe_q <= 1'b1;
						cbe_q <= `PCB_CMD_MEM_WR; // RQ3
						cbe_oe_q <= 1'b1;
					end
				end
				PCB_M_ADDR: begin
					m_st_q <= PCB_M_DATA;
					frame_n_q <= 1'b1;
					irdy_n_q <= 1'b0; // RQ6
					irdy_oe_q <= 1'b1;
					cbe_q <= `PCB_BE_ALL; // RQ3
					m_cnt_q <= '0;
				end
				PCB_M_DATA: begin
					m_cnt_q <= 3'(m_cnt_q + 1'b1);
					if (m_end) begin
						m_st_q <= PCB_M_TURN;
						irdy_n_q <= 1'b1;
						frame_oe_q <= 1'b0;
						cbe_oe_q <= 1'b0;
						m_retry_q <= bus_i.trdy_n & ~bus_i.stop_n; // RQ12
						dma_done_q <= ~bus_i.trdy_n;
						dma_err_q <= bus_i.trdy_n & bus_i.stop_n;
					end
				end
				PCB_M_TURN: begin
					irdy_oe_q <= 1'b0;
					m_st_q <= m_retry_q ? PCB_M_REQ : PCB_M_IDLE;
					req_n_q <= ~m_retry_q;
				end
				default: m_st_q <= PCB_M_IDLE;
			endcase
		end
	end

	// Address/data drivers shared by both roles
	always_ff @(posedge ref_clk) begin
		if (brst) begin
			ad_q <= '0;
			ad_oe_q <= 1'b0;
		end else if (m_go) begin
			ad_q <= dma_i.addr;
			ad_oe_q <= 1'b1;
		end else if (m_st_q == PCB_M_ADDR) begin
			ad_q <= dma_i.data;
		end else if (m_end) begin
			ad_oe_q <= 1'b0;
		end else if (t_st_q == PCB_T_DEC && !t_wr_q) begin
			ad_q <= rd_data;
			ad_oe_q <= 1'b1;
		end else if (t_st_q == PCB_T_DATA && !bus_i.irdy_n) begin
			ad_oe_q <= 1'b0;
		end
	end

	// Parity lags the lines it covers by one clock
	always_ff @(posedge ref_clk) begin
		if (brst) begin
			par_q <= 1'b0;
			par_oe_q <= 1'b0;
		end else begin
			par_q <= even_sum(ad_q, cbe_cur); // RQ1
			par_oe_q <= ad_oe_q; // RQ2
		end
	end

	// Parity checking and error reporting
	always_ff @(posedge ref_clk) begin
		if (brst) begin
			sum_q <= 1'b0;
			a_chk_q <= 1'b0;
			d_chk_q <= 1'b0;
			s_chk_q <= 1'b0;
			sp_q <= 1'b0;
			perr_n_q <= 1'b1;
			perr_oe_q <= 1'b0;
			serr_oe_q <= 1'b0;
			m_pwin_q <= '0;
			perr_seen_q <= 1'b0;
		end else begin
			sum_q <= even_sum(bus_i.ad, bus_i.cbe);
			a_chk_q <= addr_ph;
			d_chk_q <= t_xfer & t_wr_q;
			s_chk_q <= sp_q & ~bus_i.irdy_n;
			if (addr_ph)
				sp_q <= bus_i.cbe == `PCB_CMD_SPECIAL;
			else if (!bus_i.irdy_n)
				sp_q <= 1'b0;
			serr_oe_q <= ((a_chk_q | s_chk_q) & bad) | sys_err; // RQ18
			if (d_chk_q && bad) begin
				perr_n_q <= 1'b0; // RQ16 RQ17
				perr_oe_q <= 1'b1;
			end else if (!perr_n_q) begin
				perr_n_q <= 1'b1;
			end else begin
				perr_oe_q <= 1'b0;
			end
			m_pwin_q <= {m_pwin_q[0], dma_done_q};
			perr_seen_q <= (|m_pwin_q) & ~bus_i.perr_n; // RQ17
		end
	end

	// Sideband: interrupt, wake, clock run
	always_ff @(posedge ref_clk) begin
		if (brst) begin
			inta_oe_q <= 1'b0;
			pme_oe_q <= 1'b0;
			clkrun_oe_q <= 1'b0;
			clk_run_q <= 1'b0;
		end else begin
			inta_oe_q <= irq_req; // RQ15
			pme_oe_q <= pme_req; // RQ13
			clk_run_q <= ~bus_i.clkrun_n; // RQ14
			clkrun_oe_q <= card_mode & (dma_valid | irq_req | pme_req) &
				bus_i.clkrun_n & ~clkrun_oe_q; // RQ14 RQ20
		end
	end

	assign bus_o = '{ad: ad_q, ad_oe: ad_oe_q, cbe: cbe_q, cbe_oe: cbe_oe_q,
		par: par_q, par_oe: par_oe_q, frame_n: frame_n_q, frame_oe: frame_oe_q,
		irdy_n: irdy_n_q, irdy_oe: irdy_oe_q, trdy_n: trdy_n_q, devsel_n: devsel_n_q,
		stop_n: stop_n_q, tgt_oe: tgt_oe_q, perr_n: perr_n_q, perr_oe: perr_oe_q,
		serr_oe: serr_oe_q, req_n: req_n_q, pme_oe: pme_oe_q, inta_oe: inta_oe_q,
		clkrun_oe: clkrun_oe_q};
	assign dma_done = dma_done_q;
	assign dma_err = dma_err_q;
	assign perr_seen = perr_seen_q;
	assign clk_running = clk_run_q;

	default clocking cb @(posedge ref_clk); // RQ19
	endclocking
	default disable iff (brst);

	a_par_even: assert property (par_oe_q |-> (par_q == ^{$past(ad_q), $past(cbe_cur)})) // RQ1
		else $error("parity not even");
	a_par_drive: assert property (ad_oe_q |=> par_oe_q) // RQ2
		else $error("parity not driven after data");
	a_cmd_out: assert property (m_go |=> cbe_oe_q && cbe_q == `PCB_CMD_MEM_WR ##1 cbe_q == 4'h0) // RQ3
		else $error("command or enables wrong");
	a_frame_start: assert property (m_go |=> !frame_n_q && frame_oe_q ##1 frame_n_q && !irdy_n_q) // RQ4
		else $error("frame sequence wrong");
	a_trdy_claim: assert property (tgt_oe_q && !trdy_n_q |-> !devsel_n_q) // RQ5
		else $error("ready without select");
	a_irdy_data: assert property (irdy_oe_q && !irdy_n_q |-> ad_oe_q) // RQ6
		else $error("ready without data");
	a_gnt_first: assert property (m_st_q == PCB_M_ADDR |-> $past(!bus_i.gnt_n) && $past(!req_n_q)) // RQ9
		else $error("start without grant");
	a_cfg_idsel: assert property (addr_ph && !bus_i.idsel && bus_i.cbe == `PCB_CMD_CFG_WR
		&& t_st_q == PCB_T_IDLE |=> t_st_q == PCB_T_IDLE) // RQ10
		else $error("config claimed without select");
	a_devsel_claim: assert property (t_st_q == PCB_T_IDLE && addr_ph && t_claim
		|=> !devsel_n_q ##1 !stop_n_q) // RQ11
		else $error("claim not signalled");
	a_stop_ends: assert property (m_st_q == PCB_M_DATA && !bus_i.stop_n && bus_i.trdy_n
		|=> m_st_q == PCB_M_TURN ##1 m_st_q == PCB_M_REQ) // RQ12
		else $error("no retry after stop");
	a_perr_rx: assert property (d_chk_q && bad |=> !perr_n_q && perr_oe_q && !ad_oe_q) // RQ17
		else $error("parity error not reported");
	a_reset_idle: assert property (@(posedge ref_clk) disable iff (rst)
		!host_bus_reset_in_n |=> !ad_oe_q && !frame_oe_q && req_n_q && !tgt_oe_q) // RQ21
		else $error("outputs not released in reset");
	c_tgt_write: cover property (t_xfer && t_wr_q);
	c_tgt_read: cover property (t_xfer && !t_wr_q);
	c_mst_done: cover property (dma_done_q);
	c_mst_retry: cover property (m_st_q == PCB_M_TURN && m_retry_q);
endmodule : pcb_host_port
`default_nettype wire

// File: verif/pcb_host_model.sv
`default_nettype none
module pcb_host_model
	import pcb_pkg::*;
(
	input wire logic ref_clk,
	input wire pcb_bus_out_t bus_o,
	input wire logic gnt_ok,
	input wire logic dev_ok,
	input wire logic clkrun_n,
	output var pcb_bus_in_t bus_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] ad_h = 32'h0000_0000;
	logic [31:0] cap_addr;
	logic [31:0] cap_data;
	logic [3:0] cbe_h = 4'h0;
	logic ad_hoe = 1'b0, cbe_hoe = 1'b0, par_h = 1'b0, par_hoe = 1'b0, bad = 1'b0, tog = 1'b0;
	logic frame_h = 1'b1, irdy_h = 1'b1, idsel_h = 1'b0, gnt_n = 1'b1;
	logic devsel_h = 1'b1, trdy_h = 1'b1;
	logic [1:0] st = 2'h0;
	// Released AD, CBE and PAR lines toggle so stale values never look valid
	assign bus_i = '{ad: bus_o.ad_oe ? bus_o.ad : ad_hoe ? ad_h : {16{tog, ~tog}},
		cbe: bus_o.cbe_oe ? bus_o.cbe : cbe_hoe ? cbe_h : {2{tog, ~tog}},
		par: bus_o.par_oe ? bus_o.par : par_hoe ? par_h : tog,
		frame_n: bus_o.frame_oe ? bus_o.frame_n : frame_h,
		irdy_n: bus_o.irdy_oe ? bus_o.irdy_n : irdy_h,
		trdy_n: bus_o.tgt_oe ? bus_o.trdy_n : trdy_h,
		devsel_n: bus_o.tgt_oe ? bus_o.devsel_n : devsel_h,
		stop_n: bus_o.tgt_oe ? bus_o.stop_n : 1'b1,
		perr_n: !bus_o.perr_oe,
		idsel: idsel_h, gnt_n: gnt_n,
		clkrun_n: clkrun_n & !bus_o.clkrun_oe};
	always_ff @(posedge ref_clk) begin
		tog <= ~tog;
		par_h <= ^{ad_h, cbe_h} ^ bad;
		par_hoe <= ad_hoe;
		gnt_n <= !(!bus_o.req_n && gnt_ok);
	end
	// Target for the device's own master cycles
	always_ff @(posedge ref_clk) begin
		if (st == 2'h0 && bus_o.frame_oe && !bus_o.frame_n) begin
			cap_addr <= bus_i.ad;
			st <= dev_ok ? 2'h1 : 2'h0;
		end else if (st == 2'h1) begin
			devsel_h <= 1'b0;
			st <= 2'h2;
		end else if (st == 2'h2) begin
			trdy_h <= 1'b0;
			st <= 2'h3;
		end else if (st == 2'h3 && !bus_i.irdy_n) begin
			cap_data <= bus_i.ad;
			devsel_h <= 1'b1;
			trdy_h <= 1'b1;
			st <= 2'h0;
		end
	end
	task automatic host_cyc(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] data,
		input logic [3:0] be, input logic sel, input logic wr, input logic perr_bad,
		output logic claim, output logic retry, output logic [31:0] rdv, output logic par_ok,
		output logic perr_hit);
		@(posedge ref_clk);
		frame_h <= 1'b0;
		ad_hoe <= 1'b1;
		cbe_hoe <= 1'b1;
		ad_h <= addr;
		cbe_h <= cmd;
		idsel_h <= sel;
		@(posedge ref_clk);
		frame_h <= 1'b1;
		irdy_h <= 1'b0;
		cbe_h <= be;
		ad_h <= data;
		ad_hoe <= wr;
		bad <= perr_bad;
		claim = 1'b0;
		perr_hit = 1'b0;
		for (int n = 0; n < 8; n++) begin
			@(posedge ref_clk);
			if (!bus_i.devsel_n) claim = 1'b1;
			if (!bus_i.trdy_n || !bus_i.stop_n) break;
		end
		retry = bus_i.trdy_n;
		rdv = bus_i.ad;
		irdy_h <= 1'b1;
		ad_hoe <= 1'b0;
		cbe_hoe <= 1'b0;
		idsel_h <= 1'b0;
		bad <= 1'b0;
		@(posedge ref_clk);
		par_ok = (bus_i.par === ^{rdv, be});
		repeat (4) begin
			@(posedge ref_clk);
			if (!bus_i.perr_n) perr_hit = 1'b1;
		end
	endtask : host_cyc
endmodule : pcb_host_model
`default_nettype wire

// File: verif/tb.sv
`include "pcb_defs.svh"
`default_nettype none
module tb
	import pcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [3:0] cmd; logic [31:0] addr; logic sel; logic claim;} pcb_row_t;
	logic ref_clk, rst, host_bus_reset_in_n, card_mode, wr_valid, wr_ready, dma_valid, dma_done;
	logic dma_err, irq_req, pme_req, sys_err, perr_seen, clk_running, gnt_ok, dev_ok, clkrun_n;
	logic cl, rt, po, ph;
	logic [31:0] rd_data, rv;
	pcb_bus_in_t bus_i;
	pcb_bus_out_t bus_o;
	pcb_wr_t wr_o;
	pcb_dma_t dma_i;
	int fails, checked, cnt;
	pcb_row_t rows [4] = '{'{`PCB_CMD_CFG_WR, 32'h0000_0010, 1'b1, 1'b1},
		'{`PCB_CMD_CFG_WR, 32'h0000_0010, 1'b0, 1'b0},
		'{`PCB_CMD_MEM_WR, 32'h8000_0A00, 1'b0, 1'b1},
		'{`PCB_CMD_MEM_WR, 32'h8000_1000, 1'b0, 1'b0}};
	pcb_host_port i_dut (.ref_clk(ref_clk), .rst(rst), .host_bus_reset_in_n(host_bus_reset_in_n),
		.card_mode(card_mode), .bus_i(bus_i), .bus_o(bus_o), .wr_o(wr_o), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .rd_data(rd_data), .dma_valid(dma_valid), .dma_i(dma_i),
		.dma_done(dma_done), .dma_err(dma_err), .irq_req(irq_req), .pme_req(pme_req),
		.sys_err(sys_err), .perr_seen(perr_seen), .clk_running(clk_running));
	pcb_host_model i_host (.ref_clk(ref_clk), .bus_o(bus_o), .gnt_ok(gnt_ok), .dev_ok(dev_ok),
		.clkrun_n(clkrun_n), .bus_i(bus_i));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic complete_run();
		if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input logic ok, input string m);
		checked++;
		if (!ok) begin
			fails++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic chk_idle();
		chk({bus_o.ad_oe, bus_o.cbe_oe, bus_o.par_oe, bus_o.frame_oe, bus_o.irdy_oe, bus_o.tgt_oe,
			bus_o.perr_oe, bus_o.serr_oe, bus_o.req_n, wr_valid} === 10'h002, "outputs not idle");
	endtask : chk_idle
	task automatic dma_run(input logic exp_err);
		int n;
		dma_i <= '{32'h8100_0040, 32'h3C3C_0001};
		dma_valid <= 1'b1;
		// Arbiter stalls the grant first
		repeat (6) @(posedge ref_clk);
		chk(bus_o.req_n === 1'b0 && bus_o.frame_oe === 1'b0, "request or early start");
		gnt_ok <= 1'b1;
		for (n = 0; n < 40 && dma_done !== 1'b1 && dma_err !== 1'b1; n++) @(posedge ref_clk);
		if (n == 40) begin
			fails++;
			complete_run();
		end
		dma_valid <= 1'b0;
		gnt_ok <= 1'b0;
		chk(dma_err === exp_err, "abort flag");
		chk(exp_err || {i_host.cap_addr, i_host.cap_data} === dma_i, "dma data");
	endtask : dma_run
	initial begin
		{rst, host_bus_reset_in_n, card_mode, dev_ok} = 4'hF;
		{wr_ready, dma_valid, irq_req, pme_req, sys_err, gnt_ok, clkrun_n} = 7'h00;
		rd_data = 32'h5A5A_0F0F;
		dma_i = '0;
		fails = 0;
		checked = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk_idle();
		foreach (rows[i]) begin
			i_host.host_cyc(rows[i].cmd, rows[i].addr, {28'h1234_000, 4'(i)}, 4'(i), rows[i].sel,
				1'b1, 1'b0, cl, rt, rv, po, ph);
			chk(cl === rows[i].claim, "claim");
			chk(wr_valid === rows[i].claim && ph === 1'b0, "push or perr");
			chk(!rows[i].claim || wr_o === {rows[i].addr, 28'h1234_000, 4'(i), 4'(i)}, "word");
			wr_ready <= 1'b1;
			@(posedge ref_clk);
			wr_ready <= 1'b0;
		end
		for (int i = 0; i < 9; i++) begin
			i_host.host_cyc(`PCB_CMD_MEM_WR, `PCB_WIN_BASE | 32'(i * 4), 32'hD000_0000 | 32'(i),
				`PCB_BE_ALL, 1'b0, 1'b1, 1'b0, cl, rt, rv, po, ph);
			chk(rt === (i == 8), "retry on full");
		end
		cnt = 0;
		wr_ready <= 1'b1;
		repeat (16) begin
			@(posedge ref_clk);
			if (wr_valid === 1'b1) begin
				chk(wr_o.data === (32'hD000_0000 | 32'(cnt)), "fifo order");
				cnt++;
			end
		end
		wr_ready <= 1'b0;
		chk(cnt == 8, "fifo depth");
		i_host.host_cyc(`PCB_CMD_MEM_RD, 32'h8000_0004, 32'h0000_0000, 4'h3, 1'b0, 1'b0, 1'b0, cl,
			rt, rv, po, ph);
		chk(rv === rd_data && po === 1'b1, "read data or parity");
		i_host.host_cyc(`PCB_CMD_CFG_WR, 32'h0000_0020, 32'h0F0F_0001, 4'h0, 1'b1, 1'b1, 1'b1, cl,
			rt, rv, po, ph);
		chk(ph === 1'b1, "perr not driven");
		wr_ready <= 1'b1;
		@(posedge ref_clk);
		wr_ready <= 1'b0;
		dma_run(1'b0);
		dev_ok <= 1'b0;
		dma_run(1'b1);
		dev_ok <= 1'b1;
		card_mode <= 1'b0;
		{irq_req, pme_req, sys_err, clkrun_n} <= 4'hF;
		repeat (3) @(posedge ref_clk);
		chk({bus_o.inta_oe, bus_o.pme_oe, clk_running} === 3'h6, "side pins");
		chk(bus_o.serr_oe === 1'b1, "serr");
		chk(bus_o.clkrun_oe === 1'b0, "clkrun in bus mode");
		card_mode <= 1'b1;
		{irq_req, pme_req, sys_err, clkrun_n} <= 4'h0;
		repeat (3) @(posedge ref_clk);
		chk({bus_o.inta_oe, bus_o.pme_oe, clk_running} === 3'h1, "side pins");
		chk(bus_o.serr_oe === 1'b0, "serr stuck");
		{pme_req, clkrun_n} <= 2'h3;
		repeat (2) @(posedge ref_clk);
		chk(bus_o.clkrun_oe === 1'b1, "clkrun request");
		{pme_req, clkrun_n} <= 2'h0;
		dma_valid <= 1'b1;
		repeat (3) @(posedge ref_clk);
		host_bus_reset_in_n <= 1'b0;
		dma_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_idle();
		host_bus_reset_in_n <= 1'b1;
		complete_run();
	end
endmodule : tb
`default_nettype wire
